// file: hw/stpm_map.vh
// Constants of the stepper position and stepout monitor: register offsets,
// field positions, reset values and timing figures.
// Assumes a 50 MHz ref_clk and a word-indexed register port.
//
// Notes on behaviour
// - Moving-average filter acts only when filter select is 1; 0 is default.
// - Moving-average time is set from 0 to 200 ms, default 1 ms.
// - Command position is a signed 32-bit count of issued step pulses.
// - Command position clears to zero when return-to-home completes.
// - Position preset input loads the command position with the preset value.
// - With detection on and motor unexcited, command position follows the encoder.
// - Quadrature encoder is decoded with four counts per encoder cycle.
// - Encoder preset command loads the encoder counter with its preset value.
// - Encoder edges are counted whether or not detection is enabled.
// - Detection enable 1 compares command and encoder position; default 0.
// - Deviation error when deviation reaches the band, 1 to 3600 tenths, default 72.
// - Deviation checking starts after 500 ms of continuous excitation.
// - Deviation checking is suppressed during return to mechanical home.
// - Action setting: 0 nothing, 1 warning, 2 alarm; default 0.
// - Deviation flag can be routed to any one of six general outputs.
// - Deviation error clears on excitation off or mechanical home, and on counter clear unless checking is on and the deviation still reaches the band.
// - Alarm needs alarm clear first, then a deviation-clearing action.
// - Encoder resolution affects the comparison and the encoder refresh of command position, never the raw encoder count.
`ifndef STPM_MAP_VH
`define STPM_MAP_VH

// ****************************************
// Register indices
// ****************************************
`define STPM_A_CTRL       4'h0
`define STPM_A_MA_TIME    4'h1
`define STPM_A_BAND       4'h2
`define STPM_A_ENC_RES    4'h3
`define STPM_A_PRESET     4'h4
`define STPM_A_ENC_PRE    4'h5
`define STPM_A_CMD        4'h6
`define STPM_A_CMD_POS    4'h7
`define STPM_A_ENC_CNT    4'h8
`define STPM_A_STATUS     4'h9

// ****************************************
// Field positions and codes
// ****************************************
`define STPM_B_FILT_SEL   0
`define STPM_B_SO_EN      1
`define STPM_B_ACT_LO     2
`define STPM_B_ACT_HI     3
`define STPM_B_OSEL_LO    4
`define STPM_B_OSEL_HI    6
`define STPM_B_CMD_ENCPRE 0
`define STPM_B_CMD_CLR    1
`define STPM_ACT_WARN     2'h1
`define STPM_ACT_ALARM    2'h2
`define STPM_OSEL_LAST    3'h5

// ****************************************
// Reset values
// ****************************************
`define STPM_RST_CTRL     7'h00
`define STPM_RST_MA       8'h01
`define STPM_RST_BAND     12'h048
`define STPM_RST_RES      14'h01F4

// ****************************************
// Timing and scaling
// ****************************************
`define STPM_CLK_KHZ      32'h0000_C350
`define STPM_EXC_MS       32'h0000_01F4
`define STPM_TICK_MS      32'h0000_0001
`define STPM_MA_MAX       8'hC8
`define STPM_STEP_TENTHS  7'h48
`define STPM_ENC_SCALE    14'h2328
`define STPM_BAND_SCALE   4'hA
`define STPM_REFR_MUL     8'h7D

`endif

// file: hw/stpm_ram.v
// Sample store of the moving-average filter: 256 words of 16 bits.
// Assumes one write and one read port on the same clock; read data registered.
`timescale 1ns/1ps

module stpm_ram (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        wr_en,
  input  wire [7:0]  waddr,
  input  wire [15:0] wdata,
  input  wire [7:0]  raddr,
  output reg  [15:0] rdata_ff
);

  reg [15:0] mem [0:255];

  // Storage array, written on request.
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read, valid one cycle after the address.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= mem[raddr];
    end
  end

endmodule // stpm_ram

// file: hw/stpm_div.v
// Serial restoring divider, one quotient bit per clock.
// Assumes start is only raised while busy and done are both low.
`timescale 1ns/1ps

module stpm_div #(
  parameter DW = 40,
  parameter VW = 16
) (
  input  wire          ref_clk,
  input  wire          rst_n,
  input  wire          start,
  input  wire [DW-1:0] dividend,
  input  wire [VW-1:0] divisor,
  output reg           busy_ff,
  output reg           done_ff,
  output reg  [DW-1:0] quo_ff
);

  reg  [VW-1:0] rem_ff;
  reg  [VW-1:0] dvs_ff;
  reg  [5:0]    cnt_ff;
  wire [VW:0]   trial = {rem_ff, quo_ff[DW-1]};
  wire          fits  = (trial >= {1'b0, dvs_ff});
  wire [VW:0]   diff  = trial - {1'b0, dvs_ff};

  // Shift the dividend through, subtracting the divisor where it fits.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      quo_ff  <= {DW{1'b0}};
      rem_ff  <= {VW{1'b0}};
      dvs_ff  <= {VW{1'b0}};
      cnt_ff  <= 6'h00;
    end else begin
      done_ff <= 1'b0;
      if (start && !busy_ff) begin
        busy_ff <= 1'b1;
        quo_ff  <= dividend;
        rem_ff  <= {VW{1'b0}};
        dvs_ff  <= divisor;
        cnt_ff  <= DW[5:0];
      end else if (busy_ff) begin
        rem_ff <= fits ? diff[VW-1:0] : trial[VW-1:0];
        quo_ff <= {quo_ff[DW-2:0], fits};
        cnt_ff <= cnt_ff - 6'h01;
        if (cnt_ff == 6'h01) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end

endmodule // stpm_div

// file: hw/stpm_top.v
// Position tracking and stepout monitor of a stepping motor driver: speed
// command averaging, command position, quadrature encoder count, deviation check.
// Assumes step pulses, excitation and home status come from logic on ref_clk;
// encoder and host inputs are asynchronous pins.
`timescale 1ns/1ps
`include "stpm_map.vh"

module stpm_top #(
  parameter [31:0] EXC_CYC  = `STPM_EXC_MS * `STPM_CLK_KHZ,
  parameter [31:0] TICK_CYC = `STPM_TICK_MS * `STPM_CLK_KHZ
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_ff,
  input  wire        step_pulse,
  input  wire        step_dir,
  input  wire        excited,
  input  wire        home_done,
  input  wire        mech_home_busy,
  input  wire        pos_preset_pin,
  input  wire        alarm_clear_input,
  input  wire        enc_a,
  input  wire        enc_b,
  input  wire [15:0] speed_cmd,
  output reg  [15:0] speed_out_ff,
  output reg  [5:0]  general_output_ff,
  output reg         dev_warning_ff,
  output reg         dev_alarm_ff
);

  // ****************************************
  // Helper functions
  // ****************************************
  // Magnitude of a two's complement word.
  function [31:0] abs32;
    input [31:0] v;
    begin
      abs32 = v[31] ? (~v + 32'h0000_0001) : v;
    end
  endfunction

  function [63:0] abs64;
    input [63:0] v;
    begin
      abs64 = v[63] ? (~v + 64'h0000_0000_0000_0001) : v;
    end
  endfunction

  // Sign extension of a 24-bit preset to the 32-bit counters.
  function [31:0] sext24;
    input [23:0] v;
    begin
      sext24 = {{8{v[23]}}, v};
    end
  endfunction

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RD   = 5'h02;
  localparam [4:0] S_UPD  = 5'h04;
  localparam [4:0] S_GO   = 5'h08;
  localparam [4:0] S_DIV  = 5'h10;

  // ****************************************
  // Registers and decode
  // ****************************************
  reg  [6:0]  ctrl_ff;
  reg  [7:0]  ma_time_ff;
  reg  [11:0] band_ff;
  reg  [13:0] enc_res_ff;
  reg  [23:0] preset_pos_ff;
  reg  [23:0] enc_preset_ff;
  reg  [31:0] cmd_pos_ff;
  reg  [31:0] enc_cnt_ff;
  reg         dev_err_ff;
  reg         alarm_seen_ff;

  wire        filt_sel  = ctrl_ff[`STPM_B_FILT_SEL];
  wire        so_en     = ctrl_ff[`STPM_B_SO_EN];
  wire [1:0]  action    = ctrl_ff[`STPM_B_ACT_HI:`STPM_B_ACT_LO];
  wire [2:0]  out_sel   = ctrl_ff[`STPM_B_OSEL_HI:`STPM_B_OSEL_LO];
  wire        cmd_wr    = reg_wr && (reg_addr == `STPM_A_CMD);
  wire        enc_pre   = cmd_wr && reg_wdata[`STPM_B_CMD_ENCPRE];
  wire        cnt_clear = cmd_wr && reg_wdata[`STPM_B_CMD_CLR];
  wire        ma_reset  = reg_wr && ((reg_addr == `STPM_A_MA_TIME) ||
                                     (reg_addr == `STPM_A_CTRL));

  // Settings writes; reset values give the documented defaults.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff       <= `STPM_RST_CTRL;
      ma_time_ff    <= `STPM_RST_MA;
      band_ff       <= `STPM_RST_BAND;
      enc_res_ff    <= `STPM_RST_RES;
      preset_pos_ff <= 24'h00_0000;
      enc_preset_ff <= 24'h00_0000;
    end else if (reg_wr) begin
      case (reg_addr)
        `STPM_A_CTRL:    ctrl_ff       <= reg_wdata[6:0];
        `STPM_A_MA_TIME: ma_time_ff    <= reg_wdata[7:0];
        `STPM_A_BAND:    band_ff       <= reg_wdata[11:0];
        `STPM_A_ENC_RES: enc_res_ff    <= reg_wdata[13:0];
        `STPM_A_PRESET:  preset_pos_ff <= reg_wdata[23:0];
        `STPM_A_ENC_PRE: enc_preset_ff <= reg_wdata[23:0];
        default:         ctrl_ff       <= ctrl_ff;
      endcase
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Bits: 0 encoder A, 1 encoder B, 2 position preset, 3 alarm clear.
  reg  [3:0] s1_ff;
  reg  [3:0] s2_ff;
  reg  [3:0] s3_ff;
  reg  [3:0] flt_ff;
  reg  [3:0] prev_ff;
  wire [3:0] pins = {alarm_clear_input, pos_preset_pin, enc_b, enc_a};

  // A filtered level follows only once the second and third stages agree.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff   <= 4'h0;
      s2_ff   <= 4'h0;
      s3_ff   <= 4'h0;
      flt_ff  <= 4'h0;
      prev_ff <= 4'h0;
    end else begin
      s1_ff   <= pins;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      flt_ff  <= (s2_ff & s3_ff) | (flt_ff & (s2_ff ^ s3_ff));
      prev_ff <= flt_ff;
    end
  end

  wire quad_step = flt_ff[0] ^ prev_ff[0] ^ flt_ff[1] ^ prev_ff[1];
  wire quad_up   = flt_ff[0] ^ prev_ff[1];
  wire preset_rq = flt_ff[2] & ~prev_ff[2];
  wire alm_edge  = flt_ff[3] & ~prev_ff[3];

  // ****************************************
  // Encoder counter
  // ****************************************
  // Counts every legal quadrature edge, four per encoder line cycle.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_cnt_ff <= 32'h0000_0000;
    end else if (cnt_clear) begin
      enc_cnt_ff <= 32'h0000_0000;
    end else if (enc_pre) begin
      enc_cnt_ff <= sext24(enc_preset_ff);
    end else if (quad_step) begin
      enc_cnt_ff <= quad_up ? enc_cnt_ff + 32'h0000_0001 : enc_cnt_ff - 32'h0000_0001;
    end
  end

  // ****************************************
  // Command position and encoder refresh
  // ****************************************
  wire        refr_on  = so_en && !excited;
  wire [31:0] enc_abs  = abs32(enc_cnt_ff);
  wire [39:0] refr_dvd = {8'h00, enc_abs} * {32'h0000_0000, `STPM_REFR_MUL};
  wire        ra_busy;
  wire        ra_done;
  wire [39:0] ra_quo;
  reg         refr_neg_ff;
  wire        ra_start = refr_on && !ra_busy && !ra_done;

  // Encoder steps convert to motor steps by the configured resolution.
  stpm_div #(.DW(40), .VW(16)) u_refr_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .start    (ra_start),
    .dividend (refr_dvd),
    .divisor  ({2'b00, enc_res_ff}),
    .busy_ff  (ra_busy),
    .done_ff  (ra_done),
    .quo_ff   (ra_quo)
  );

  wire [31:0] refr_pos = refr_neg_ff ? (~ra_quo[31:0] + 32'h0000_0001) : ra_quo[31:0];

  // Home completion and clear win, then preset, refresh, then step counting.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_pos_ff  <= 32'h0000_0000;
      refr_neg_ff <= 1'b0;
    end else begin
      if (ra_start) begin
        refr_neg_ff <= enc_cnt_ff[31];
      end
      if (home_done || cnt_clear) begin
        cmd_pos_ff <= 32'h0000_0000;
      end else if (preset_rq) begin
        cmd_pos_ff <= sext24(preset_pos_ff);
      end else if (ra_done && refr_on) begin
        cmd_pos_ff <= refr_pos;
      end else if (step_pulse) begin
        cmd_pos_ff <= step_dir ? cmd_pos_ff + 32'h0000_0001 : cmd_pos_ff - 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // Deviation check
  // ****************************************
  reg  [31:0] exc_cnt_ff;
  reg         chk_on_ff;
  reg  [63:0] dev_abs_ff;
  reg  [31:0] thr_ff;
  wire [20:0] step_res = {7'h00, enc_res_ff} * {14'h0000, `STPM_STEP_TENTHS};
  wire [63:0] cmd_term = {{32{cmd_pos_ff[31]}}, cmd_pos_ff} * {43'h0, step_res};
  wire [63:0] enc_term = {{32{enc_cnt_ff[31]}}, enc_cnt_ff} * {50'h0, `STPM_ENC_SCALE};
  wire [31:0] thr      = {20'h0_0000, band_ff} * {28'h000_0000, `STPM_BAND_SCALE} *
                         {18'h0_0000, enc_res_ff};

  // Excitation settle timer, and the angle difference in common units.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      exc_cnt_ff <= 32'h0000_0000;
      chk_on_ff  <= 1'b0;
      dev_abs_ff <= 64'h0000_0000_0000_0000;
      thr_ff     <= 32'h0000_0000;
    end else begin
      if (!excited) begin
        exc_cnt_ff <= 32'h0000_0000;
      end else if (exc_cnt_ff != EXC_CYC) begin
        exc_cnt_ff <= exc_cnt_ff + 32'h0000_0001;
      end
      chk_on_ff  <= so_en && excited && (exc_cnt_ff == EXC_CYC) && !mech_home_busy;
      dev_abs_ff <= abs64(cmd_term - enc_term);
      thr_ff     <= thr;
    end
  end

  wire dev_hit   = chk_on_ff && !mech_home_busy && (dev_abs_ff >= {32'h0, thr_ff});
  wire dev_clr   = !excited || mech_home_busy || cnt_clear;
  wire nxt_err   = dev_hit ? 1'b1 : (dev_clr ? 1'b0 : dev_err_ff);
  wire alarm_set = dev_hit && (action == `STPM_ACT_ALARM);
  wire nxt_alarm = alarm_set ? 1'b1 : ((alarm_seen_ff && dev_clr) ? 1'b0 : dev_alarm_ff);

  // Error latch, warning, alarm and output routing.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_err_ff        <= 1'b0;
      dev_warning_ff    <= 1'b0;
      dev_alarm_ff      <= 1'b0;
      alarm_seen_ff     <= 1'b0;
      general_output_ff <= 6'h00;
    end else begin
      dev_err_ff     <= nxt_err;
      dev_warning_ff <= nxt_err && (action == `STPM_ACT_WARN);
      dev_alarm_ff   <= nxt_alarm;
      // The alarm clear is only remembered while an alarm stands.
      alarm_seen_ff  <= (nxt_alarm && !alarm_set) ? (alarm_seen_ff | alm_edge) : 1'b0;
      general_output_ff <= (out_sel <= `STPM_OSEL_LAST) ?
                           ((6'h01 << out_sel) & {6{nxt_err}}) : 6'h00;
    end
  end

  // ****************************************
  // Moving-average filter
  // ****************************************
  reg  [4:0]  ma_st_ff;
  reg  [31:0] tick_cnt_ff;
  reg  [7:0]  wptr_ff;
  reg  [7:0]  fill_ff;
  reg  [23:0] sum_ff;
  reg  [15:0] sample_ff;
  wire [15:0] old_word;
  wire        mb_done;
  wire [39:0] mb_quo;
  wire [7:0]  ma_n   = (ma_time_ff > `STPM_MA_MAX) ? `STPM_MA_MAX : ma_time_ff;
  wire        bypass = !filt_sel || (ma_n == 8'h00);
  wire        tick   = (tick_cnt_ff == TICK_CYC - 32'h0000_0001);
  wire [15:0] old_s  = (fill_ff >= ma_n) ? old_word : 16'h0000;

  // Ring of past samples, one per millisecond.
  stpm_ram u_ram (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .wr_en    (ma_st_ff == S_UPD),
    .waddr    (wptr_ff),
    .wdata    (sample_ff),
    .raddr    (wptr_ff - ma_n),
    .rdata_ff (old_word)
  );

  stpm_div #(.DW(40), .VW(16)) u_avg_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .start    (ma_st_ff == S_GO),
    .dividend ({16'h0000, sum_ff}),
    .divisor  ({8'h00, ma_n}),
    .busy_ff  (),
    .done_ff  (mb_done),
    .quo_ff   (mb_quo)
  );

  // Window sum keeps the newest samples; their mean is the shaped speed.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ma_st_ff     <= S_IDLE;
      tick_cnt_ff  <= 32'h0000_0000;
      wptr_ff      <= 8'h00;
      fill_ff      <= 8'h00;
      sum_ff       <= 24'h00_0000;
      sample_ff    <= 16'h0000;
      speed_out_ff <= 16'h0000;
    end else if (ma_reset) begin
      ma_st_ff    <= S_IDLE;
      tick_cnt_ff <= 32'h0000_0000;
      fill_ff     <= 8'h00;
      sum_ff      <= 24'h00_0000;
      // A settings write must not stall the bypassed speed for a cycle.
      if (bypass) begin
        speed_out_ff <= speed_cmd;
      end
    end else begin
      tick_cnt_ff <= tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
      case (ma_st_ff)
        S_IDLE: begin
          if (tick && !bypass) begin
            sample_ff <= speed_cmd;
            ma_st_ff  <= S_RD;
          end
        end
        S_RD: begin
          ma_st_ff <= S_UPD;
        end
        S_UPD: begin
          sum_ff   <= sum_ff + {8'h00, sample_ff} - {8'h00, old_s};
          wptr_ff  <= wptr_ff + 8'h01;
          fill_ff  <= (fill_ff == 8'hFF) ? fill_ff : fill_ff + 8'h01;
          ma_st_ff <= S_GO;
        end
        S_GO: begin
          ma_st_ff <= S_DIV;
        end
        S_DIV: begin
          if (mb_done) begin
            speed_out_ff <= mb_quo[15:0];
            ma_st_ff     <= S_IDLE;
          end
        end
        default: begin
          ma_st_ff <= S_IDLE;
        end
      endcase
      if (bypass) begin
        speed_out_ff <= speed_cmd;
      end
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  // Read data stand in the cycle after the strobe; unmapped reads give zero.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `STPM_A_CTRL:    reg_rdata_ff <= {25'h000_0000, ctrl_ff};
        `STPM_A_MA_TIME: reg_rdata_ff <= {24'h00_0000, ma_time_ff};
        `STPM_A_BAND:    reg_rdata_ff <= {20'h0_0000, band_ff};
        `STPM_A_ENC_RES: reg_rdata_ff <= {18'h0_0000, enc_res_ff};
        `STPM_A_PRESET:  reg_rdata_ff <= {8'h00, preset_pos_ff};
        `STPM_A_ENC_PRE: reg_rdata_ff <= {8'h00, enc_preset_ff};
        `STPM_A_CMD_POS: reg_rdata_ff <= cmd_pos_ff;
        `STPM_A_ENC_CNT: reg_rdata_ff <= enc_cnt_ff;
        `STPM_A_STATUS:  reg_rdata_ff <= {27'h000_0000, alarm_seen_ff, chk_on_ff,
                                          dev_alarm_ff, dev_warning_ff, dev_err_ff};
        default:         reg_rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_ff <= 32'h0000_0000;
    end
  end

endmodule // stpm_top

// file: verif/stpm_chk_asserts.sv
// Port checker of the stepout monitor.
// Assumes bind into stpm_top; every input is a port of it.
`timescale 1ns/1ps
module stpm_chk #(
  parameter [31:0] EXC_CYC = 32'h0000_0014
) (
  input wire        ref_clk,
  input wire        rst_n,
  input wire [3:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata_ff,
  input wire        excited,
  input wire        mech_home_busy,
  input wire        alarm_clear_input,
  input wire [15:0] speed_cmd,
  input wire [15:0] speed_out_ff,
  input wire [5:0]  general_output_ff,
  input wire        dev_warning_ff,
  input wire        dev_alarm_ff
);
  reg [31:0] exc_n_ff;
  reg        byp_ff;
  reg        clr_ff;
  // Tracks excited time, filter bypass and alarm clear requests.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      exc_n_ff <= 32'h0000_0000;
      byp_ff   <= 1'b1;
      clr_ff   <= 1'b0;
    end else begin
      exc_n_ff <= excited ? exc_n_ff + 32'h0000_0001 : 32'h0000_0000;
      byp_ff   <= (reg_wr && reg_addr == 4'h0) ? !reg_wdata[0] : byp_ff;
      clr_ff   <= dev_alarm_ff && (clr_ff || alarm_clear_input);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_one_kind: assert property (!(dev_warning_ff && dev_alarm_ff))
    else $error("warning and alarm high together");
  chk_out_onehot: assert property ($onehot0(general_output_ff))
    else $error("error flag on more than one output");
  chk_exc_clear: assert property (!excited [*6] |-> !dev_warning_ff && general_output_ff == 6'h00)
    else $error("error kept without excitation");
  chk_home_quiet: assert property (mech_home_busy [*6] |-> !dev_warning_ff)
    else $error("error during mechanical home");
  chk_exc_time: assert property ($rose(dev_warning_ff || dev_alarm_ff) |-> exc_n_ff >= EXC_CYC)
    else $error("error raised before excitation time");
  chk_alarm_hold: assert property ($fell(dev_alarm_ff) |-> clr_ff)
    else $error("alarm dropped without alarm clear");
  chk_bypass_out: assert property (byp_ff && $past(byp_ff) |-> speed_out_ff == $past(speed_cmd))
    else $error("bypassed speed differs");
  chk_rd_idle: assert property (!reg_rd |=> reg_rdata_ff == 32'h0000_0000)
    else $error("read data without read");
  cover property ($rose(dev_warning_ff));
  cover property ($rose(dev_alarm_ff));
  cover property ($fell(dev_alarm_ff));
endmodule // stpm_chk

// file: verif/stpm_pins.sv
// Far-side model: quadrature encoder and host pins of the stepout monitor.
// Assumes the bench calls its tasks; pins change just after ref_clk rises.
`timescale 1ns/1ps
module stpm_pins (
  input  wire ref_clk,
  output reg  enc_a,
  output reg  enc_b,
  output reg  pos_preset_pin,
  output reg  alarm_clear_input
);
  integer ph = 0;
  // Pins idle low at power up.
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    pos_preset_pin = 1'b0;
    alarm_clear_input = 1'b0;
  end
  // One count per phase step, A leading B upward; each level held hold plus one cycles.
  task move(input integer n, input integer hold);
    repeat (n < 0 ? -n : n) begin
      ph = (ph + (n < 0 ? 3 : 1)) % 4;
      @(posedge ref_clk);
      enc_a <= ph == 1 || ph == 2;
      enc_b <= ph >= 2;
      repeat (hold) @(posedge ref_clk);
    end
  endtask
  // Host pin pulse of eight cycles: 0 presets position, 1 clears the alarm.
  task pulse(input integer which);
    @(posedge ref_clk);
    if (which == 1) alarm_clear_input <= 1'b1;
    else pos_preset_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    pos_preset_pin <= 1'b0;
    alarm_clear_input <= 1'b0;
  endtask
endmodule // stpm_pins

// file: verif/tb.sv
// Self-checking bench of the stepout monitor against an integer model.
// Assumes stpm_top, stpm_pins and stpm_chk; short excitation and tick counts.
`timescale 1ns/1ps
module tb;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [31:0] reg_wdata = 32'h0000_0000;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         step_pulse = 1'b0;
  reg         step_dir = 1'b0;
  reg         excited = 1'b0;
  reg         home_done = 1'b0;
  reg         mech_home_busy = 1'b0;
  reg  [15:0] speed_cmd = 16'h0000;
  reg  [15:0] sv;
  reg  [31:0] d;
  wire [31:0] reg_rdata_ff;
  wire [15:0] speed_out_ff;
  wire [5:0]  general_output_ff;
  wire        dev_warning_ff;
  wire        dev_alarm_ff;
  wire        enc_a;
  wire        enc_b;
  wire        pos_preset_pin;
  wire        alarm_clear_input;
  integer     n_errors = 0;
  integer     compares = 0;
  integer     seed = 32'h4938;
  integer     exp_cmd = 0;
  integer     act;
  integer     dr;
  stpm_top #(.EXC_CYC(32'h0000_0014), .TICK_CYC(32'h0000_003C)) u_dut (.*);
  stpm_pins u_pins (.*);
  // Clock of 20 ns.
  always #10 ref_clk = ~ref_clk;
  // Compares one result and counts it.
  task chk(input [8*6-1:0] nm, input [31:0] e, input [31:0] g);
    compares = compares + 1;
    if (e !== g) begin
      n_errors = n_errors + 1;
      $display("wrong value %0s expected %h seen %h", nm, e, g);
    end
  endtask
  // One-cycle register write.
  task wr(input [3:0] a, input [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle register read; data taken in the following cycle.
  task rd(input [3:0] a, output [31:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_ff;
  endtask
  // Reads a register and compares it.
  task rchk(input [8*6-1:0] nm, input [3:0] a, input [31:0] e);
    rd(a, d);
    chk(nm, e, d);
  endtask
  // Compares alarm, warning and the six general outputs.
  task flg(input [7:0] e);
    #1 chk("flags", e, {dev_alarm_ff, dev_warning_ff, general_output_ff});
  endtask
  // Issues n step pulses, random or forward, and tracks the position; speed varies too.
  task steps(input integer n, input integer rnd);
    repeat (n) begin
      dr = rnd ? $random(seed) & 1 : 1;
      exp_cmd = exp_cmd + (dr ? 1 : -1);
      @(posedge ref_clk);
      step_pulse <= 1'b1;
      step_dir <= dr;
      speed_cmd <= ($random(seed) & 16'h7FFE) | 16'h0002;
      @(posedge ref_clk);
      step_pulse <= 1'b0;
    end
  endtask
  // Waits, bounded, for the shaped speed to change.
  task wchg(output [15:0] v);
    integer k;
    v = speed_out_ff;
    for (k = 0; k < 300 && speed_out_ff === v; k = k + 1) begin
      @(posedge ref_clk);
      #1;
    end
    if (k == 300) begin
      n_errors = n_errors + 1;
      summarize;
    end else begin
      v = speed_out_ff;
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task summarize;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    speed_cmd <= ($random(seed) & 16'h7FFE) | 16'h0002;
    rchk("ctrl", 4'h0, 32'h0000_0000);
    rchk("ma", 4'h1, 32'h0000_0001);
    rchk("band", 4'h2, 32'h0000_0048);
    rchk("res", 4'h3, 32'h0000_01F4);
    wr(4'h8, 32'h0000_0055);
    wr(4'hA, 32'h0000_0055);
    rchk("enc", 4'h8, 32'h0000_0000);
    rchk("unmap", 4'hA, 32'h0000_0000);
    rchk("cmdreg", 4'h6, 32'h0000_0000);
    steps(20, 1);
    rchk("cmdpos", 4'h7, exp_cmd);
    wr(4'h4, 32'h00FF_FFFB);
    u_pins.pulse(0);
    repeat (8) @(posedge ref_clk);
    rchk("cmdpos", 4'h7, 32'hFFFF_FFFB);
    @(posedge ref_clk);
    home_done <= 1'b1;
    @(posedge ref_clk);
    home_done <= 1'b0;
    rchk("cmdpos", 4'h7, 32'h0000_0000);
    u_pins.move(10, 4);
    u_pins.move(-3, 9);
    repeat (8) @(posedge ref_clk);
    rchk("enc", 4'h8, 32'h0000_0007);
    wr(4'h5, 32'h0000_0064);
    wr(4'h6, 32'h0000_0001);
    wr(4'h3, 32'h0000_03E8);
    rchk("enc", 4'h8, 32'h0000_0064);
    wr(4'h0, 32'h0000_0002);
    repeat (120) @(posedge ref_clk);
    rchk("cmdpos", 4'h7, 32'h0000_000C);
    wr(4'h3, 32'h0000_01F4);
    for (act = 0; act < 4; act = act + 1) begin
      excited <= 1'b0;
      wr(4'h0, ((2 * act + 1) << 4) | (act << 2) | 2);
      wr(4'h6, 32'h0000_0002);
      excited <= 1'b1;
      repeat (30) @(posedge ref_clk);
      steps(9, 0);
      repeat (8) @(posedge ref_clk);
      flg(8'h00);
      steps(1, 0);
      repeat (8) @(posedge ref_clk);
      flg({act == 2, act == 1, 6'h01 << (2 * act + 1)});
      rd(4'h9, d);
      chk("status", {act == 2, act == 1, 1'b1}, d[2:0]);
      mech_home_busy <= 1'b1;
      repeat (8) @(posedge ref_clk);
      flg({act == 2, 7'h00});
      mech_home_busy <= 1'b0;
      excited <= 1'b0;
      repeat (8) @(posedge ref_clk);
      flg({act == 2, 7'h00});
      u_pins.pulse(1);
      repeat (8) @(posedge ref_clk);
      flg(8'h00);
    end
    wr(4'h1, 32'h0000_0002);
    wr(4'h0, 32'h0000_0001);
    wchg(sv);
    chk("avg", speed_cmd >> 1, sv);
    wchg(sv);
    chk("avg", speed_cmd, sv);
    summarize;
  end
endmodule // tb
bind stpm_top stpm_chk #(.EXC_CYC(EXC_CYC)) u_chk (.*);
